// *** fault_resp_defs.vh ***
`ifndef FAULT_RESP_DEFS_VH
`define FAULT_RESP_DEFS_VH
// =====================================================
// Fault record codes
`define FC_NONE        8'h00
`define FC_OC          8'h01
`define FC_OV          8'h02
`define FC_GF          8'h03
`define FC_SW          8'h04
`define FC_OC_CONST    8'h08
`define FC_OC_ACCEL    8'h09
`define FC_OC_DECEL    8'h0A
`define FC_LINK        8'h15
`define FC_LOOP        8'h16
`define FC_TUNE        8'h18
`define FC_BRAKE       8'h19
`define FC_UV_RUN      8'h24
`define FC_OV_DECEL    8'h25
`define FC_UV          8'h27
`define FC_BLOCK       8'h28
// =====================================================
// Motion phase encoding
`define PH_IDLE        2'h0
`define PH_CONST       2'h1
`define PH_ACCEL       2'h2
`define PH_DECEL       2'h3
// =====================================================
// Exception codes
`define EX_NONE        8'h00
`define EX_VALUE       8'h01
`define EX_ADDR        8'h02
`define EX_PASSWORD    8'h03
`define EX_RUNNING     8'h04
`define EX_STORE       8'h05
`define EX_LENGTH      8'h06
`define EX_READ_ONLY   8'h07
`define EX_UNDERVOLT   8'h08
`define EX_READ_LOCK   8'h09
`define EX_TIMEOUT     8'h0A
`define EX_FRAMING     8'h0B
`define EX_PARITY      8'h0C
// =====================================================
// Reply framing
`define FUNC_EXC_BIT   8'h80
`define LOCK_READ_BIT  0
`define ACTION_MAX     2'h2
`define ASCII_START    8'h3A
`define ASCII_CR       8'h0D
`define ASCII_LF       8'h0A
`define ASCII_DIGIT    8'h30
`define ASCII_ALPHA    8'h37
`define NIBBLE_TEN     4'hA
`define CRC_INIT       16'hFFFF
`define CRC_POLY       16'hA001
`define RTU_LAST       4'h4
`define ASCII_LAST     4'hA
// Timeout unit is 0.1 s
`define TIMEOUT_UNIT_NS 100000000
`define CLK_PERIOD_NS   4
`endif

// *** fault_code_and_exception_responder.v ***
// Overview of operation
// RULE1: Report latest trip cause as code 0-4
// RULE2: Over-current codes 8, 9, 10 by phase
// RULE3: Codes 21, 22, 24, 25 for listed faults
// RULE4: Codes 36, 37, 39, 40 for listed faults
// RULE5: Corrupted request gets no reply whatsoever
// RULE6: Unexecutable request gets exception reply, displayed
// RULE7: Echo function with MSB set, one code
// RULE8: RTU reply: address, function, code, CRC
// RULE9: Code 01 bad value, 02 bad address
// RULE10: Writes refused: 03 password, 04 running
// RULE11: Code 05 store failure, 06 bad length
// RULE12: Write to read-only parameter gives 07
// RULE13: Undervoltage: reads served, writes give 08
// RULE14: Lock bit 0 set rejects reads, 09
// RULE15: Timeout code 10 under three conditions
// RULE16: Framing error 11, parity error 12
// RULE17: ASCII reply: colon, hex, LRC, CRLF
`include "fault_resp_defs.vh"
module fault_code_and_exception_responder
#(
   parameter TICK_CYCLES = `TIMEOUT_UNIT_NS / `CLK_PERIOD_NS
)
(
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Trip events, one-cycle pulses
   input  wire        overcurrent_trip,
   input  wire [1:0]  motion_phase,
   input  wire        overvoltage_trip,
   input  wire        overvoltage_decel_trip,
   input  wire        ground_fault_trip,
   input  wire        power_switch_failure,
   input  wire        serial_link_error,
   input  wire        loop_controller_error,
   input  wire        autotune_failure,
   input  wire        brake_chopper_failure,
   input  wire        undervoltage_trip,
   input  wire        external_output_block,
   input  wire        fault_clear,
   // Drive state
   input  wire        motor_running,
   input  wire        undervoltage_state,
   input  wire        password_locked,
   input  wire [7:0]  parameter_lock_setting,
   // Link settings
   input  wire        ascii_mode,
   input  wire [15:0] link_timeout_period,
   input  wire [1:0]  link_fault_action,
   input  wire        bus_activity,
   // Decoded request
   input  wire        req_valid,
   output wire        req_ready,
   input  wire [7:0]  req_address,
   input  wire [7:0]  req_function,
   input  wire        req_is_write,
   input  wire        req_framing_error,
   input  wire        req_parity_error,
   input  wire        req_addr_bad,
   input  wire        req_value_bad,
   input  wire        req_length_bad,
   input  wire        req_read_only,
   input  wire        req_store_failed,
   // Reply byte stream
   output wire        tx_valid,
   input  wire        tx_ready,
   output reg  [7:0]  tx_data_r,
   output wire        tx_last,
   // Status
   output reg  [7:0]  fault_code_r,
   output reg  [7:0]  link_error_display_code,
   output reg         link_timeout_r
);

   localparam ST_IDLE = 2'd0;
   localparam ST_LOAD = 2'd1;
   localparam ST_SEND = 2'd2;
   reg  [1:0]  state_r;
   reg  [3:0]  idx_r, char_pos;
   reg         ascii_r;
   reg  [7:0]  addr_r, func_r, exc_r, chk_lo_r, chk_hi_r;
   reg  [7:0]  trip_nxt, exc_nxt, char_nxt, cur_byte, lrc_val;
   reg  [31:0] tick_r;
   reg  [15:0] units_r, crc_val;
   // =====================================================
   // Fault record
   always @*
   begin
      trip_nxt = `FC_NONE;
      if (external_output_block) trip_nxt = `FC_BLOCK;          // see RULE4
      else if (undervoltage_trip)
         trip_nxt = motor_running ? `FC_UV_RUN : `FC_UV; // see RULE4
      else if (overvoltage_decel_trip) trip_nxt = `FC_OV_DECEL; // see RULE4
      else if (brake_chopper_failure) trip_nxt = `FC_BRAKE;     // see RULE3
      else if (autotune_failure) trip_nxt = `FC_TUNE;           // see RULE3
      else if (loop_controller_error) trip_nxt = `FC_LOOP;      // see RULE3
      else if (serial_link_error) trip_nxt = `FC_LINK;          // see RULE3
      else if (power_switch_failure) trip_nxt = `FC_SW;         // see RULE1
      else if (ground_fault_trip) trip_nxt = `FC_GF;            // see RULE1
      else if (overvoltage_trip) trip_nxt = `FC_OV;             // see RULE1
      else if (overcurrent_trip)
         case (motion_phase)                        // see RULE2
            `PH_CONST: trip_nxt = `FC_OC_CONST;
            `PH_ACCEL: trip_nxt = `FC_OC_ACCEL;
            `PH_DECEL: trip_nxt = `FC_OC_DECEL;
            default:   trip_nxt = `FC_OC;           // see RULE1
         endcase
   end
   // A trip in the same cycle as a clear is kept
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         fault_code_r <= `FC_NONE;
      else if (trip_nxt != `FC_NONE)
         fault_code_r <= trip_nxt;                  // see RULE1
      else if (fault_clear)
         fault_code_r <= `FC_NONE;
   end
   // =====================================================
   // Exception selection
   always @*
   begin
      exc_nxt = `EX_NONE;
      if (req_addr_bad) exc_nxt = `EX_ADDR;                   // see RULE9
      else if (req_value_bad) exc_nxt = `EX_VALUE;            // see RULE9
      else if (req_length_bad) exc_nxt = `EX_LENGTH;          // see RULE11
      else if (!req_is_write)                                 // see RULE14
         exc_nxt = parameter_lock_setting[`LOCK_READ_BIT] ? `EX_READ_LOCK
                                                          : `EX_NONE;
      else if (req_read_only) exc_nxt = `EX_READ_ONLY;        // see RULE12
      else if (password_locked) exc_nxt = `EX_PASSWORD;       // see RULE10
      else if (undervoltage_state) exc_nxt = `EX_UNDERVOLT;   // see RULE13
      else if (motor_running) exc_nxt = `EX_RUNNING;          // see RULE10
      else if (req_store_failed) exc_nxt = `EX_STORE;         // see RULE11
   end
   // =====================================================
   // Checksums over address, function and exception code
   function [15:0] crc3;
      input [23:0] bytes;
      integer      i;
      reg   [15:0] c;
      begin
         c = `CRC_INIT;
         for (i = 0; i < 24; i = i + 1)
         begin
            if (i % 8 == 0)
               c = c ^ {8'h00, bytes[23 - i -: 8]};
            c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
         end
         crc3 = c;
      end
   endfunction
   function [7:0] hex_char;
      input [3:0] n;
      begin
         hex_char = (n < `NIBBLE_TEN) ? (`ASCII_DIGIT + {4'h0, n})
                                      : (`ASCII_ALPHA + {4'h0, n});
      end
   endfunction
   always @*
   begin
      crc_val = crc3({req_address, req_function | `FUNC_EXC_BIT, exc_nxt});
      lrc_val = 8'h00 - (req_address + (req_function | `FUNC_EXC_BIT)
                + exc_nxt);
   end
   // =====================================================
   // Reply character at current index; ASCII sends high nibble first
   always @*
   begin
      char_pos = idx_r - 4'h1;
      char_nxt = `ASCII_START;
      case (char_pos[2:1])
         2'h0:    cur_byte = addr_r;
         2'h1:    cur_byte = func_r;
         2'h2:    cur_byte = exc_r;
         default: cur_byte = chk_lo_r;
      endcase
      if (!ascii_r)
      begin
         case (idx_r)                               // see RULE8
            4'h0:    char_nxt = addr_r;
            4'h1:    char_nxt = func_r;
            4'h2:    char_nxt = exc_r;
            4'h3:    char_nxt = chk_lo_r;
            default: char_nxt = chk_hi_r;
         endcase
      end
      else if (idx_r == `ASCII_LAST)
         char_nxt = `ASCII_LF;                      // see RULE17
      else if (idx_r == `ASCII_LAST - 4'h1)
         char_nxt = `ASCII_CR;                      // see RULE17
      else if (idx_r != 4'h0)
         char_nxt = hex_char(char_pos[0] ? cur_byte[3:0] : cur_byte[7:4]);
   end
   assign req_ready = (state_r == ST_IDLE);
   assign tx_valid  = (state_r == ST_SEND);
   assign tx_last   = tx_valid &&
                      (idx_r == (ascii_r ? `ASCII_LAST : `RTU_LAST));
   // =====================================================
   // Reply sequencer and display
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_r   <= ST_IDLE;
         idx_r     <= 4'h0;
         ascii_r   <= 1'b0;
         addr_r    <= 8'h00;
         func_r    <= 8'h00;
         exc_r     <= 8'h00;
         chk_lo_r  <= 8'h00;
         chk_hi_r  <= 8'h00;
         tx_data_r <= 8'h00;
         link_error_display_code <= `EX_NONE;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               if (req_valid)
               begin
                  if (req_framing_error)                     // see RULE5
                     link_error_display_code <= `EX_FRAMING; // see RULE16
                  else if (req_parity_error)
                     link_error_display_code <= `EX_PARITY;  // see RULE16
                  else if (exc_nxt != `EX_NONE)
                  begin
                     link_error_display_code <= exc_nxt;     // see RULE6
                     addr_r   <= req_address;
                     func_r   <= req_function | `FUNC_EXC_BIT; // see RULE7
                     exc_r    <= exc_nxt;
                     chk_lo_r <= ascii_mode ? lrc_val : crc_val[7:0];
                     chk_hi_r <= crc_val[15:8];
                     ascii_r  <= ascii_mode;
                     idx_r    <= 4'h0;
                     state_r  <= ST_LOAD;
                  end
                  else if (link_timeout_r)
                     link_error_display_code <= `EX_NONE;
               end
               else if (link_timeout_r)
                  link_error_display_code <= `EX_TIMEOUT;    // see RULE15
            end
            ST_LOAD:
            begin
               tx_data_r <= char_nxt;
               state_r   <= ST_SEND;
            end
            ST_SEND:
            begin
               if (tx_ready)
               begin
                  if (tx_last)
                     state_r <= ST_IDLE;
                  else
                  begin
                     idx_r   <= idx_r + 4'h1;
                     state_r <= ST_LOAD;
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
   // =====================================================
   // Silent-bus watchdog; activity restarts and clears it
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tick_r         <= 32'h0;
         units_r        <= 16'h0;
         link_timeout_r <= 1'b0;
      end
      else if (bus_activity || link_timeout_period == 16'h0 ||
               link_fault_action > `ACTION_MAX)
      begin
         tick_r         <= 32'h0;
         units_r        <= 16'h0;
         link_timeout_r <= 1'b0;
      end
      else if (!link_timeout_r)
      begin
         if (tick_r == TICK_CYCLES - 1)
         begin
            tick_r <= 32'h0;
            if (units_r + 16'h1 == link_timeout_period)
               link_timeout_r <= 1'b1;              // see RULE15
            units_r <= units_r + 16'h1;
         end
         else
            tick_r <= tick_r + 32'h1;
      end
   end
endmodule // fault_code_and_exception_responder

// *** fault_resp_chk.sv ***
module fault_resp_chk (
   // Clock and reset
   input logic        clk,
   input logic        rst,
   // Request side
   input logic        req_valid,
   input logic        req_ready,
   input logic        req_framing_error,
   input logic        req_parity_error,
   input logic        req_addr_bad,
   // Reply and status
   input logic        tx_valid,
   input logic        tx_ready,
   input logic [7:0]  tx_data_r,
   input logic        external_output_block,
   input logic [7:0]  fault_code_r,
   input logic [7:0]  link_error_display_code,
   input logic        link_timeout_r,
   input logic [15:0] link_timeout_period,
   input logic [1:0]  link_fault_action
);
   timeunit 1ns;
   timeprecision 1ps;
   wire take  = req_valid && req_ready;
   wire clean = take && !req_framing_error && !req_parity_error;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ==========================================
   // Request outcome
   chk_addr_reply: assert property (
      clean && req_addr_bad |-> ##2 tx_valid)
      else $error("no reply to a bad address");
   chk_addr_code: assert property (
      clean && req_addr_bad |=> link_error_display_code == 8'h02)
      else $error("wrong code for a bad address");
   chk_corrupt_quiet: assert property (
      take && (req_framing_error || req_parity_error) |=> !tx_valid [*4])
      else $error("reply sent to a corrupted request");
   chk_frame_code: assert property (
      take && req_framing_error && !req_parity_error
      |=> link_error_display_code == 8'h0B)
      else $error("wrong framing error code");
   chk_parity_code: assert property (
      take && req_parity_error && !req_framing_error
      |=> link_error_display_code == 8'h0C)
      else $error("wrong parity error code");
   // ==========================================
   // Reply stream and status
   chk_busy_refuse: assert property (
      tx_valid |-> !req_ready && link_error_display_code != 8'h00)
      else $error("request accepted or code hidden during a reply");
   chk_byte_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data_r))
      else $error("reply byte dropped before it was taken");
   chk_block_code: assert property (
      external_output_block |=> fault_code_r == 8'h28)
      else $error("output block trip not recorded");
   chk_timeout_cause: assert property (
      $rose(link_timeout_r) |-> $past(link_timeout_period) != 16'h0000
      && $past(link_fault_action) <= 2'h2)
      else $error("timeout raised while disabled");
endmodule // fault_resp_chk

bind fault_code_and_exception_responder fault_resp_chk u_chk (
   .clk, .rst, .req_valid, .req_ready, .req_framing_error,
   .req_parity_error, .req_addr_bad, .tx_valid, .tx_ready, .tx_data_r,
   .external_output_block, .fault_code_r, .link_error_display_code,
   .link_timeout_r, .link_timeout_period, .link_fault_action);

// *** modbus_master_model.sv ***
module modbus_master_model (
   // Clock, reset and pace
   input  logic       clk,
   input  logic       rst,
   input  logic       slow,
   // Reply stream from the drive
   input  logic       tx_valid,
   input  logic [7:0] tx_data_r,
   input  logic       tx_last,
   output logic       tx_ready,
   // Bytes taken, last flag on top
   output logic       rx_stb,
   output logic [8:0] rx_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   // A missing reply is left to the master's own timeout
   always @(posedge clk or posedge rst)
      if (rst)
      begin
         tx_ready <= 1'b0;
         rx_stb   <= 1'b0;
         rx_byte  <= 9'h000;
      end
      else
      begin
         // Random stalls make the drive hold each byte
         tx_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
         rx_stb   <= tx_valid && tx_ready;
         rx_byte  <= {tx_last, tx_data_r};
      end
endmodule // modbus_master_model

// *** test_fault_code_and_exception_responder.sv ***
`define CMP(a, b) begin total_checks++; if ((a) !== (b)) begin \
   err_count++; $display("mismatch t=%0t got %h exp %h", $time, a, b); \
   end end
module test_fault_code_and_exception_responder;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Signals
   logic        clk = 1'b0, rst = 1'b1, fault_clear = 1'b0;
   logic        motor_running = 1'b0, undervoltage_state = 1'b0;
   logic        password_locked = 1'b0, ascii_mode = 1'b0, slow = 1'b0;
   logic        bus_activity = 1'b0, req_valid = 1'b0, req_is_write = 1'b0;
   logic [1:0]  motion_phase = 2'h0, link_fault_action = 2'h0;
   logic [7:0]  parameter_lock_setting = 8'h00;
   logic [7:0]  req_address = 8'h00, req_function = 8'h00;
   logic [15:0] link_timeout_period = 16'h0000;
   logic [10:0] trp = 11'h000;
   logic [6:0]  eb = 7'h00;
   logic [8:0]  nb;
   logic [8:0]  q[$];
   wire         req_ready, tx_valid, tx_ready, tx_last, link_timeout_r;
   wire         rx_stb;
   wire  [7:0]  tx_data_r, fault_code_r, link_error_display_code;
   wire  [8:0]  rx_byte;
   int          err_count = 0, total_checks = 0, n;
   // Trip mask, {running, phase}, expected record
   logic [31:0] trips[17] = '{
      32'h0001_00_01, 32'h0001_01_08, 32'h0001_02_09, 32'h0001_03_0A,
      32'h0002_00_02, 32'h0004_00_25, 32'h0008_00_03, 32'h0010_00_04,
      32'h0020_00_15, 32'h0040_00_16, 32'h0080_00_18, 32'h0100_00_19,
      32'h0200_00_27, 32'h0200_04_24, 32'h0400_00_28, 32'h0401_00_28,
      32'h0011_02_04};
   // Error bits, {write, lock, password, undervolt, run}, exception
   logic [23:0] reqs[15] = '{
      24'h04_00_02, 24'h08_00_01, 24'h10_00_06, 24'h00_08_09,
      24'h20_10_07, 24'h00_14_03, 24'h00_12_08, 24'h00_11_04,
      24'h40_10_05, 24'h01_00_0B, 24'h02_00_0C, 24'h00_02_00,
      24'h00_18_00, 24'h24_10_02, 24'h05_00_0B};

   fault_code_and_exception_responder #(.TICK_CYCLES(10)) DUT (.*,
      .overcurrent_trip(trp[0]), .overvoltage_trip(trp[1]),
      .overvoltage_decel_trip(trp[2]), .ground_fault_trip(trp[3]),
      .power_switch_failure(trp[4]), .serial_link_error(trp[5]),
      .loop_controller_error(trp[6]), .autotune_failure(trp[7]),
      .brake_chopper_failure(trp[8]), .undervoltage_trip(trp[9]),
      .external_output_block(trp[10]), .req_framing_error(eb[0]),
      .req_parity_error(eb[1]), .req_addr_bad(eb[2]),
      .req_value_bad(eb[3]), .req_length_bad(eb[4]),
      .req_read_only(eb[5]), .req_store_failed(eb[6]));
   modbus_master_model partner (.*);

   always #2 clk = ~clk;

   // Any byte with no note pending is an unwanted reply
   always @(posedge clk)
      if (rx_stb === 1'b1)
      begin
         nb = (q.size() != 0) ? q.pop_front() : ~rx_byte;
         `CMP(rx_byte, nb)
      end

   // ==========================================
   // Tasks
   task end_of_test;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task idle;
      n = 0;
      do
      begin
         @(posedge clk);
         #1 n++;
      end
      while ((q.size() != 0 || req_ready !== 1'b1 || tx_valid !== 1'b0)
             && n < 300);
      if (n >= 300)
      begin
         err_count++;
         end_of_test;
      end
   endtask

   function automatic logic [7:0] hx(input logic [3:0] v);
      return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
   endfunction

   task hexq(input logic [7:0] v);
      q.push_back({1'b0, hx(v[7:4])});
      q.push_back({1'b0, hx(v[3:0])});
   endtask

   task expect_reply(input logic [7:0] a, f, x, input logic m);
      logic [7:0]  b[3];
      logic [7:0]  s;
      logic [15:0] c;
      b = '{a, f | 8'h80, x};
      s = 8'h00;
      c = 16'hFFFF;
      foreach (b[i])
      begin
         s = s + b[i];
         c = c ^ {8'h00, b[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      if (m)
      begin
         q.push_back({1'b0, 8'h3A});
         foreach (b[i]) hexq(b[i]);
         hexq(8'h00 - s);
         q.push_back({1'b0, 8'h0D});
         q.push_back({1'b1, 8'h0A});
      end
      else
      begin
         foreach (b[i]) q.push_back({1'b0, b[i]});
         q.push_back({1'b0, c[7:0]});
         q.push_back({1'b1, c[15:8]});
      end
   endtask

   task trip(input logic [31:0] t);
      @(posedge clk);
      trp <= t[26:16];
      {motor_running, motion_phase} <= t[10:8];
      @(posedge clk);
      trp <= 11'h000;
      #1 `CMP(fault_code_r, t[7:0])
   endtask

   task req(input logic [23:0] t, input logic m, input logic s);
      logic [7:0] a, f;
      a = 8'($urandom);
      f = 8'($urandom_range(127, 1));
      idle;
      @(posedge clk);
      ascii_mode <= m;
      slow <= s;
      {req_is_write, parameter_lock_setting[0], password_locked,
         undervoltage_state, motor_running} <= t[12:8];
      eb <= t[22:16];
      req_address <= a;
      req_function <= f;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      eb <= 7'h00;
      // Corrupted requests (codes 11 and 12) must stay silent
      if (t[7:0] != 8'h00 && t[7:0] < 8'h0B)
         expect_reply(a, f, t[7:0], m);
      #1;
      if (t[7:0] != 8'h00)
         `CMP(link_error_display_code, t[7:0])
   endtask

   // ==========================================
   // Sequence
   initial
   begin
      void'($urandom(64215));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      foreach (trips[i]) trip(trips[i]);
      @(posedge clk);
      fault_clear <= 1'b1;
      @(posedge clk);
      fault_clear <= 1'b0;
      #1 `CMP(fault_code_r, 8'h00)
      @(posedge clk);
      trp <= 11'h002;
      fault_clear <= 1'b1;
      @(posedge clk);
      trp <= 11'h000;
      fault_clear <= 1'b0;
      #1 `CMP(fault_code_r, 8'h02)
      for (int m = 0; m < 2; m++)
         foreach (reqs[i])
            req(reqs[i], m[0], i[0]);
      idle;
      @(posedge clk);
      link_timeout_period <= 16'h0003;
      n = 0;
      do
      begin
         @(posedge clk);
         #1 n++;
      end
      while (link_timeout_r !== 1'b1 && n < 200);
      `CMP(n inside {[28:34]}, 1'b1)
      repeat (2) @(posedge clk);
      #1 `CMP(link_error_display_code, 8'h0A)
      @(posedge clk);
      bus_activity <= 1'b1;
      repeat (2) @(posedge clk);
      #1 `CMP(link_timeout_r, 1'b0)
      @(posedge clk);
      bus_activity <= 1'b0;
      link_fault_action <= 2'h3;
      repeat (60) @(posedge clk);
      #1 `CMP(link_timeout_r, 1'b0)
      @(posedge clk);
      link_fault_action <= 2'h2;
      repeat (40) @(posedge clk);
      #1 `CMP(link_timeout_r, 1'b1)
      end_of_test;
   end
endmodule // test_fault_code_and_exception_responder
